// ===== src/hpb_pkg.sv
// Purpose: constants and carrier types for the hub-to-pci bridge control slice
// Assumes: byte-addressed configuration space, 16-bit register view
// Notes:   offsets are configuration-space byte addresses
`default_nettype none
package hpb_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] IO_BASE_UPPER_OFS  = 8'h30;
  localparam logic [7:0] IO_LIMIT_UPPER_OFS = 8'h32;
  localparam logic [7:0] INT_ROUTING_OFS    = 8'h3c;
  localparam logic [7:0] BRIDGE_CONTROL_OFS = 8'h3e;

  localparam logic [15:0] IO_UPPER_VALUE    = 16'h0000;
  localparam logic [7:0]  INT_ROUTING_VALUE = 8'h00;
  localparam logic [15:0] BRIDGE_RESET      = 16'h0000;

  // ****************************************
  // bridge_control fields
  // ****************************************
  localparam int BC_FAST_B2B_BIT    = 7;
  localparam int BC_SEC_RESET_BIT   = 6;
  localparam int BC_MABORT_BIT      = 5;
  localparam int BC_VGA_BIT         = 3;
  localparam int BC_ISA_BIT         = 2;
  localparam int BC_SERR_BIT        = 1;
  localparam int BC_PARITY_BIT      = 0;
  localparam logic [15:0] BC_WRITABLE_FULL    = 16'h002f;
  localparam logic [15:0] BC_WRITABLE_REDUCED = 16'h002e;

  // ****************************************
  // decode windows
  // ****************************************
  localparam logic [31:0] VGA_MEM_LOW  = 32'h000a0000;
  localparam logic [31:0] VGA_MEM_HIGH = 32'h000bffff;
  localparam logic [15:0] VGA_IO_LOW0  = 16'h03b0;
  localparam logic [15:0] VGA_IO_HIGH0 = 16'h03bb;
  localparam logic [15:0] VGA_IO_LOW1  = 16'h03c0;
  localparam logic [15:0] VGA_IO_HIGH1 = 16'h03df;
  localparam logic [9:0]  IO_ALIAS_MASK = 10'h3ff;

  // configuration access carrier
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [1:0]  byteEn;
    logic [15:0] wdata;
  } hpb_cfg_type;

  // pci cycle presented for claim decode
  typedef struct packed {
    logic        valid;
    logic        isIo;
    logic [31:0] addr;
  } hpb_cycle_type;

endpackage
`default_nettype wire

// ===== src/hpb_claim_filter.sv
// Purpose: vetoes claims of legacy vga cycles coming from pci
// Assumes: cycle fields stable while valid
// Notes:   pure combinational veto, registered by the caller
`timescale 1ns/1ps
`default_nettype none
module hpb_claim_filter
  import hpb_pkg::*;
(
  // cycle and control
  input  wire hpb_cycle_type cycle,
  input  wire logic          vgaEnable,
  // result
  output logic               veto
);
  wire logic [9:0] ioLow   = cycle.addr[9:0] & IO_ALIAS_MASK;
  wire logic       vgaIo   = ({6'h00, ioLow} >= VGA_IO_LOW0 && {6'h00, ioLow} <= VGA_IO_HIGH0)
                          || ({6'h00, ioLow} >= VGA_IO_LOW1 && {6'h00, ioLow} <= VGA_IO_HIGH1);
  wire logic       vgaMem  = cycle.addr >= VGA_MEM_LOW && cycle.addr <= VGA_MEM_HIGH;

  // io veto holds whatever the enable says
  assign veto = cycle.valid && (cycle.isIo ? vgaIo : (vgaEnable && vgaMem));
endmodule
`default_nettype wire

// ===== src/hpb_bridge_regs.sv
// Purpose: bridge control register slice with serr and parity status
// Assumes: one clock, synchronous active-high reset, config accesses one cycle
// Notes:   read data registered one cycle after rd
`timescale 1ns/1ps
`default_nettype none

module hpb_bridge_regs
  import hpb_pkg::*;
#(
  parameter bit FULL_VARIANT = 1'b1
)(
  // clock and reset
  input  wire logic          clock,
  input  wire logic          reset,
  // configuration access
  input  wire hpb_cfg_type   cfg,
  output logic [15:0]        rdata_ff,
  // command register inputs and nmi routing
  input  wire logic          cmdSerrEnable,
  input  wire logic          nmiEnable,
  input  wire logic          nmiToSmi,
  // pci error events
  input  wire logic          serrAsserted,
  input  wire logic          internalMaster,
  input  wire logic          perrOnWrite,
  input  wire logic          readParityError,
  input  wire logic          clearSystemError,
  input  wire logic          clearParityError,
  // decode
  input  wire hpb_cycle_type pciCycle,
  output logic               claimVeto_ff,
  output logic               masterAbortMode_ff,
  output logic               fastBackToBack_ff,
  // status and interrupts
  output logic               signaledSystemError_ff,
  output logic               dataParityError_ff,
  output logic               nmi_ff,
  output logic               systemManagementInterrupt_ff
);

  // ****************************************
  // bridge control storage
  // ****************************************
  logic [15:0] bridgeCtl_ff;
  logic [15:0] nxt_bridgeCtl;
  wire logic [15:0] writeMask = FULL_VARIANT ? BC_WRITABLE_FULL : BC_WRITABLE_REDUCED;
  wire logic [15:0] laneMask  = {{8{cfg.byteEn[1]}}, {8{cfg.byteEn[0]}}};
  wire logic        ctlWrite  = cfg.wr && cfg.addr == BRIDGE_CONTROL_OFS;
  wire logic [15:0] bitsTaken = writeMask & laneMask;

  // fixed and reserved bits never take write data
  assign nxt_bridgeCtl = ctlWrite ? ((bridgeCtl_ff & ~bitsTaken) | (cfg.wdata & bitsTaken))
                                  : bridgeCtl_ff;

  always_ff @(posedge clock) begin
    if (reset) begin
      bridgeCtl_ff <= BRIDGE_RESET;
    end else begin
      bridgeCtl_ff <= nxt_bridgeCtl;
    end
  end

  wire logic vgaEnable    = bridgeCtl_ff[BC_VGA_BIT];
  wire logic serrEnable   = bridgeCtl_ff[BC_SERR_BIT];
  wire logic parityEnable = FULL_VARIANT && bridgeCtl_ff[BC_PARITY_BIT];

  // ****************************************
  // read path
  // ****************************************
  wire logic [15:0] readMux =
      (cfg.addr == IO_BASE_UPPER_OFS)  ? IO_UPPER_VALUE :
      (cfg.addr == IO_LIMIT_UPPER_OFS) ? IO_UPPER_VALUE :
      (cfg.addr == INT_ROUTING_OFS)    ? {8'h00, INT_ROUTING_VALUE} :
      (cfg.addr == BRIDGE_CONTROL_OFS) ? bridgeCtl_ff : 16'h0000;

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_ff <= 16'h0000;
    end else if (cfg.rd) begin
      rdata_ff <= readMux;
    end
  end

  // ****************************************
  // claim decode
  // ****************************************
  logic veto;
  hpb_claim_filter u_filter (
    .cycle     (pciCycle),
    .vgaEnable (vgaEnable),
    .veto      (veto)
  );

  always_ff @(posedge clock) begin
    if (reset) begin
      claimVeto_ff       <= 1'b0;
      masterAbortMode_ff <= 1'b0;
      fastBackToBack_ff  <= 1'b0;
    end else begin
      claimVeto_ff       <= veto;
      // abort handling sees a cleared mode regardless of storage
      masterAbortMode_ff <= 1'b0;
      fastBackToBack_ff  <= 1'b0;
    end
  end

  // ****************************************
  // error status and escalation
  // ****************************************
  wire logic serrEvent   = serrAsserted && serrEnable && cmdSerrEnable;
  wire logic parityEvent = parityEnable && internalMaster && (perrOnWrite || readParityError);

  // set wins over a clear in the same cycle
  wire logic nxt_sse = serrEvent || (signaledSystemError_ff && !clearSystemError);
  wire logic nxt_dpe = parityEvent || (dataParityError_ff && !clearParityError);
  wire logic escalate = serrEvent || (parityEvent && nmiEnable);

  always_ff @(posedge clock) begin
    if (reset) begin
      signaledSystemError_ff       <= 1'b0;
      dataParityError_ff           <= 1'b0;
      nmi_ff                       <= 1'b0;
      systemManagementInterrupt_ff <= 1'b0;
    end else begin
      signaledSystemError_ff       <= nxt_sse;
      dataParityError_ff           <= nxt_dpe;
      nmi_ff                       <= escalate && !nmiToSmi;
      systemManagementInterrupt_ff <= escalate && nmiToSmi;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  io_upper_zero_a: assert property (@(posedge clock) disable iff (reset)
    cfg.rd && cfg.addr == IO_BASE_UPPER_OFS |=> rdata_ff == 16'h0000)
    else $error("io base upper word not zero");
  io_limit_zero_a: assert property (@(posedge clock) disable iff (reset)
    cfg.rd && cfg.addr == IO_LIMIT_UPPER_OFS |=> rdata_ff == 16'h0000)
    else $error("io limit upper word not zero");
  int_routing_zero_a: assert property (@(posedge clock) disable iff (reset)
    cfg.rd && cfg.addr == INT_ROUTING_OFS |=> rdata_ff == 16'h0000)
    else $error("interrupt routing byte not zero");
  fixed_bits_zero_a: assert property (@(posedge clock) disable iff (reset)
    (bridgeCtl_ff & ~writeMask) == 16'h0000)
    else $error("fixed bridge control bit set");
  mabort_ignored_a: assert property (@(posedge clock) disable iff (reset)
    bridgeCtl_ff[BC_MABORT_BIT] |=> !masterAbortMode_ff)
    else $error("master abort mode honoured");
  vga_mem_veto_a: assert property (@(posedge clock) disable iff (reset)
    pciCycle.valid && !pciCycle.isIo && vgaEnable && pciCycle.addr == VGA_MEM_LOW
    |=> claimVeto_ff)
    else $error("vga memory cycle claimed");
  vga_io_veto_a: assert property (@(posedge clock) disable iff (reset)
    pciCycle.valid && pciCycle.isIo && pciCycle.addr[9:0] == VGA_IO_LOW1[9:0] |=> claimVeto_ff)
    else $error("vga io cycle claimed");
  serr_status_a: assert property (@(posedge clock) disable iff (reset)
    serrAsserted && serrEnable && cmdSerrEnable
    |=> signaledSystemError_ff && (nmi_ff || systemManagementInterrupt_ff))
    else $error("serr not escalated");
  parity_flag_a: assert property (@(posedge clock) disable iff (reset)
    !parityEnable && !dataParityError_ff |=> !dataParityError_ff)
    else $error("parity flag set while disabled");

  // ****************************************
  // storage and read-back checks
  // ****************************************
  // write data may land only in the writable positions
  ctl_write_a: assert property (@(posedge clock) disable iff (reset)
    ctlWrite && cfg.byteEn == 2'h3 |=> bridgeCtl_ff == ($past(cfg.wdata) & writeMask))
    else $error("bridge control write did not land");
  lane_keep_a: assert property (@(posedge clock) disable iff (reset)
    ctlWrite && !cfg.byteEn[0] |=> bridgeCtl_ff[7:0] == $past(bridgeCtl_ff[7:0]))
    else $error("disabled byte lane was written");
  ctl_readback_a: assert property (@(posedge clock) disable iff (reset)
    cfg.rd && cfg.addr == BRIDGE_CONTROL_OFS |=> rdata_ff == $past(bridgeCtl_ff))
    else $error("bridge control read back wrong");

  // ****************************************
  // decode checks
  // ****************************************
  mem_window_a: assert property (@(posedge clock) disable iff (reset)
    pciCycle.valid && !pciCycle.isIo && vgaEnable
    && pciCycle.addr >= VGA_MEM_LOW && pciCycle.addr <= VGA_MEM_HIGH |=> claimVeto_ff)
    else $error("vga memory window claimed");
  io_window_a: assert property (@(posedge clock) disable iff (reset)
    pciCycle.valid && pciCycle.isIo && pciCycle.addr[9:0] >= VGA_IO_LOW0[9:0]
    && pciCycle.addr[9:0] <= VGA_IO_HIGH0[9:0] |=> claimVeto_ff)
    else $error("vga io window claimed");
  idle_no_veto_a: assert property (@(posedge clock) disable iff (reset)
    !pciCycle.valid |=> !claimVeto_ff)
    else $error("veto without a cycle");

  // ****************************************
  // status and escalation checks
  // ****************************************
  serr_gated_a: assert property (@(posedge clock) disable iff (reset)
    !signaledSystemError_ff && !(serrAsserted && serrEnable && cmdSerrEnable)
    |=> !signaledSystemError_ff)
    else $error("system error flag set without enables");
  sse_clear_a: assert property (@(posedge clock) disable iff (reset)
    signaledSystemError_ff && clearSystemError && !serrEvent |=> !signaledSystemError_ff)
    else $error("system error flag not cleared");
  dpe_clear_a: assert property (@(posedge clock) disable iff (reset)
    dataParityError_ff && clearParityError && !parityEvent |=> !dataParityError_ff)
    else $error("parity flag not cleared");
  parity_nmi_a: assert property (@(posedge clock) disable iff (reset)
    parityEvent && nmiEnable && !nmiToSmi |=> nmi_ff)
    else $error("parity error did not raise nmi");
  no_escalate_a: assert property (@(posedge clock) disable iff (reset)
    !serrEvent && !parityEvent |=> !nmi_ff && !systemManagementInterrupt_ff)
    else $error("interrupt without an event");
endmodule
`default_nettype wire

// ===== dv/hpb_pci_agent.sv
// Purpose: pci-side agent raising error events and claim cycles
// Assumes: each event or cycle lasts one clock
// Notes:   released address shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module hpb_pci_agent
  import hpb_pkg::*;
(
  // clock
  input  wire logic         clock,
  // pci side
  output var hpb_cycle_type pciCycle,
  output var logic          serrAsserted,
  output var logic          perrOnWrite,
  output var logic          readParityError
);
  initial begin
    pciCycle = '0;
    serrAsserted = 1'b0;
    perrOnWrite = 1'b0;
    readParityError = 1'b0;
  end
  // k: bit0 serr, bit1 perr on write, bit2 read parity; k of zero presents a cycle
  task automatic pulse(input logic [2:0] k, input logic io, input logic [31:0] a);
    @(posedge clock);
    serrAsserted <= k[0];
    perrOnWrite <= k[1];
    readParityError <= k[2];
    pciCycle <= '{valid: (k == 3'h0), isIo: io, addr: a};
    @(posedge clock);
    {serrAsserted, perrOnWrite, readParityError} <= 3'h0;
    // a stale address must not look valid to the decoder
    pciCycle <= '{valid: 1'b0, isIo: ~io, addr: ~a};
  endtask
endmodule
`default_nettype wire

// ===== dv/tb_hpb_bridge_regs.sv
// Purpose: self-checking bench for the bridge control slice
// Assumes: full variant, fixed latencies of one clock
// Notes:   read results are scored from a queue by a watcher
`timescale 1ns/1ps
`default_nettype none
module tb_hpb_bridge_regs;
  import hpb_pkg::*;
  logic clock, reset, cmdSerrEnable, nmiEnable, nmiToSmi, internalMaster;
  logic clearSystemError, clearParityError, io, vetoOut, mabort, fb2b;
  logic rdPend = 1'b0;
  logic [1:0] lanes;
  logic signaled_system_error_flag, dpe, nmi, smi, serr, perrW, perrR;
  logic [15:0] rdata, d, expQ[$];
  logic [31:0] a;
  hpb_cfg_type cfg;
  hpb_cycle_type cyc;
  int seed, badCount, totalChecks;
  logic [7:0] ofs[5] = '{8'h30, 8'h32, 8'h3c, 8'h3e, 8'h40};
  logic [15:0] rexp[5] = '{16'h0, 16'h0, 16'h0, 16'h002f, 16'h0};
  logic [31:0] tbl[8] = '{32'ha0000, 32'hbffff, 32'h9ffff, 32'hc0000,
                          32'h3c0, 32'h3bb, 32'h3bc, 32'h7df};
  hpb_bridge_regs dut_u (.clock(clock), .reset(reset), .cfg(cfg), .rdata_ff(rdata),
    .cmdSerrEnable(cmdSerrEnable), .nmiEnable(nmiEnable), .nmiToSmi(nmiToSmi),
    .serrAsserted(serr), .internalMaster(internalMaster), .perrOnWrite(perrW),
    .readParityError(perrR), .clearSystemError(clearSystemError),
    .clearParityError(clearParityError), .pciCycle(cyc), .claimVeto_ff(vetoOut),
    .masterAbortMode_ff(mabort), .fastBackToBack_ff(fb2b),
    .signaledSystemError_ff(signaled_system_error_flag), .dataParityError_ff(dpe), .nmi_ff(nmi),
    .systemManagementInterrupt_ff(smi));
  hpb_pci_agent agent_u (.clock(clock), .pciCycle(cyc), .serrAsserted(serr),
    .perrOnWrite(perrW), .readParityError(perrR));
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stopTest();
    $display("checks=%0d mismatches=%0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [15:0] wd);
    @(posedge clock);
    cfg <= '{rd: 1'b0, wr: 1'b1, addr: ad, byteEn: lanes, wdata: wd};
    @(posedge clock);
    cfg.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [15:0] e);
    @(posedge clock);
    cfg.rd <= 1'b1;
    cfg.addr <= ad;
    expQ.push_back(e);
    @(posedge clock);
    cfg.rd <= 1'b0;
  endtask
  task automatic lv(input logic [3:0] v);
    @(posedge clock);
    {cmdSerrEnable, nmiEnable, nmiToSmi, internalMaster} <= v;
  endtask
  // e: system error flag, parity flag, nmi, smi
  task automatic ev(input logic [2:0] k, input logic [3:0] e);
    agent_u.pulse(k, 1'b0, 32'h0);
    #1;
    check({12'h0, signaled_system_error_flag, dpe, nmi, smi}, {12'h0, e});
  endtask
  function automatic logic expVeto(input logic v, input logic i, input logic [31:0] x);
    if (i) return (x[9:0] >= 10'h3b0 && x[9:0] <= 10'h3bb) ||
                  (x[9:0] >= 10'h3c0 && x[9:0] <= 10'h3df);
    return v && x >= 32'ha0000 && x <= 32'hbffff;
  endfunction
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    if (rdPend) check(rdata, expQ.pop_front());
    rdPend = cfg.rd;
  end
  // watchdog so a stalled run still reaches the verdict
  initial begin
    repeat (20000) @(posedge clock);
    badCount++;
    stopTest();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {seed, badCount, totalChecks} = {32'd60892, 32'd0, 32'd0};
    lanes = 2'h3;
    {cmdSerrEnable, nmiEnable, nmiToSmi, internalMaster} = 4'h0;
    {clearSystemError, clearParityError, reset} = 3'b001;
    cfg = '0;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) rd(ofs[i], 16'h0);
    for (int i = 0; i < 5; i++) begin
      wr(ofs[i], 16'hffff);
      rd(ofs[i], rexp[i]);
    end
    #1 check({14'h0, mabort, fb2b}, 16'h0);
    for (int i = 0; i < 4; i++) begin
      d = 16'($random(seed));
      wr(8'h3e, d);
      rd(8'h3e, d & 16'h002f);
    end
    // single byte lanes: the other lane must keep its bits
    wr(8'h3e, 16'h0000);
    lanes = 2'h2;
    wr(8'h3e, 16'h00ff);
    rd(8'h3e, 16'h0000);
    lanes = 2'h1;
    wr(8'h3e, 16'hff08);
    rd(8'h3e, 16'h0008);
    lanes = 2'h3;
    $display("done registers");
    for (int v = 0; v < 2; v++) begin
      wr(8'h3e, v ? 16'h0008 : 16'h0000);
      for (int i = 0; i < 10; i++) begin
        io = (i >= 4 && i < 8);
        a = (i < 8) ? tbl[i] : 32'h90000 + ($random(seed) & 32'h3ffff);
        agent_u.pulse(3'h0, io, a);
        #1 check({15'h0, vetoOut}, {15'h0, expVeto(v[0], io, a)});
      end
    end
    $display("done decode");
    wr(8'h3e, 16'h0002);
    ev(3'h1, 4'h0);
    lv(4'b1000);
    ev(3'h1, 4'b1010);
    @(posedge clock);
    #1 check({15'h0, nmi}, 16'h0);
    lv(4'b1010);
    ev(3'h1, 4'b1001);
    @(posedge clock);
    clearSystemError <= 1'b1;
    @(posedge clock);
    clearSystemError <= 1'b0;
    #1 check({15'h0, signaled_system_error_flag}, 16'h0);
    // event and clear in one cycle: the set must win
    @(posedge clock);
    clearSystemError <= 1'b1;
    ev(3'h1, 4'b1001);
    @(posedge clock);
    clearSystemError <= 1'b0;
    lv(4'b0101);
    ev(3'h2, 4'h0);
    wr(8'h3e, 16'h0001);
    ev(3'h2, 4'b0110);
    ev(3'h4, 4'b0110);
    @(posedge clock);
    clearParityError <= 1'b1;
    @(posedge clock);
    clearParityError <= 1'b0;
    lv(4'b0100);
    ev(3'h6, 4'h0);
    $display("done events");
    // reset in mid-run must clear storage and sticky flags
    lv(4'b0101);
    ev(3'h2, 4'b0110);
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd(8'h3e, 16'h0000);
    #1 check({12'h0, signaled_system_error_flag, dpe, nmi, smi}, 16'h0);
    $display("done reset");
    repeat (2) @(posedge clock);
    stopTest();
  end
endmodule
`default_nettype wire
